// ===== pkg/slcc_pkg.sv
package slcc_pkg;

  // ***************************************************************
  // Register map (byte addresses on the Wishbone bus)
  // ***************************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CONN = 8'h04;
  localparam logic [7:0] ADR_BAUD = 8'h08;
  localparam logic [7:0] ADR_FMT  = 8'h0C;
  localparam logic [7:0] ADR_TMO  = 8'h10;
  localparam logic [7:0] ADR_RES  = 8'h14;
  localparam logic [7:0] ADR_REJ  = 8'h18;
  localparam logic [7:0] ADR_ISTS = 8'h1C;
  localparam logic [7:0] ADR_IMSK = 8'h20;

  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_CMD   = 1;
  localparam int CTRL_BUSY  = 8;
  localparam int RES_DONE   = 16;
  localparam int FMT_DB     = 0;
  localparam int FMT_PAR    = 4;
  localparam int FMT_STOP   = 8;
  localparam int FMT_FLOW   = 12;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_ERR    = 1;
  localparam int IRQ_REJ    = 2;

  // Command codes understood by the handler
  localparam logic [2:0] CMD_OPEN  = 3'h0;
  localparam logic [2:0] CMD_READ  = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;

  // Completion codes
  localparam logic [15:0] RES_OK     = 16'h0000;
  localparam logic [15:0] ERR_UNKN   = 16'h2497;
  localparam logic [15:0] ERR_OPEN   = 16'h2498;
  localparam logic [15:0] ERR_RX     = 16'h2499;
  localparam logic [15:0] ERR_TX     = 16'h249A;
  localparam logic [15:0] ERR_TMO    = 16'h249D;
  localparam logic [15:0] ERR_BUSY   = 16'h249E;
  localparam logic [15:0] ERR_CONN   = 16'h249F;
  localparam logic [15:0] ERR_BAUD   = 16'h24A0;
  localparam logic [15:0] ERR_DBITS  = 16'h24A1;
  localparam logic [15:0] ERR_PARITY = 16'h24A2;
  localparam logic [15:0] ERR_STOP   = 16'h24A3;
  localparam logic [15:0] ERR_FLOW   = 16'h24A4;
  localparam logic [15:0] ERR_VRD    = 16'h24AC;
  localparam logic [15:0] ERR_VWR    = 16'h24AD;

  // Legal parameter limits
  localparam logic [15:0] CONN_MIN  = 16'h4B15;
  localparam logic [15:0] CONN_MAX  = 16'h4B63;
  localparam logic [3:0]  DBITS_MIN = 4'h5;
  localparam logic [3:0]  DBITS_MAX = 4'h8;
  localparam logic [3:0]  PAR_MAX   = 4'h2;
  localparam logic [3:0]  STOP_MIN  = 4'h1;
  localparam logic [3:0]  STOP_MAX  = 4'h2;
  localparam logic [3:0]  FLOW_MAX  = 4'h2;

  // Timing: timeout unit is one millisecond
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] DEF_TMO_MS    = 16'h03E8;

  // Merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] slcc_wr16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = dat[7:0];
    if (sel[1]) r[15:8] = dat[15:8];
    return r;
  endfunction : slcc_wr16

endpackage : slcc_pkg

// ===== rtl/slcc_param_check.sv
`timescale 1ns/10ps
`default_nettype none
module slcc_param_check
  import slcc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] conn_i,
  input  wire logic [15:0] baud_i,
  input  wire logic [15:0] fmt_i,
  output logic      [15:0] err_o
);

  logic [3:0] db, par, stp, flw;
  assign db  = fmt_i[FMT_DB+:4];
  assign par = fmt_i[FMT_PAR+:4];
  assign stp = fmt_i[FMT_STOP+:4];
  assign flw = fmt_i[FMT_FLOW+:4];

  // Only the ten listed rates are legal
  function automatic logic baud_ok(input logic [15:0] b);
    unique case (b)
      16'h004B, 16'h006E, 16'h0096, 16'h012C, 16'h0258,
      16'h04B0, 16'h0960, 16'h12C0, 16'h2580, 16'h4B00: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : baud_ok

  // First failing field wins, in descriptor order
  always_comb begin
    if (conn_i < CONN_MIN || conn_i > CONN_MAX)   err_o = ERR_CONN;   // RULE9
    else if (!baud_ok(baud_i))                    err_o = ERR_BAUD;   // RULE10
    else if (db < DBITS_MIN || db > DBITS_MAX)    err_o = ERR_DBITS;  // RULE11
    else if (par > PAR_MAX)                       err_o = ERR_PARITY; // RULE12
    else if (stp < STOP_MIN || stp > STOP_MAX)    err_o = ERR_STOP;   // RULE13
    else if (flw > FLOW_MAX)                      err_o = ERR_FLOW;   // RULE14
    else                                          err_o = RES_OK;
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  AST_CONN_RANGE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    (conn_i == 16'h4B14 || conn_i == 16'h4B64) |-> err_o == ERR_CONN)
    else $error("Connection number out of range not flagged");
  AST_BAUD_BAD: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    (conn_i == CONN_MIN && baud_i == 16'h0064) |-> err_o == ERR_BAUD)
    else $error("Illegal baud rate not flagged");
  AST_FMT_DBITS: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    (err_o != ERR_CONN && err_o != ERR_BAUD && db == 4'h9) |-> err_o == ERR_DBITS)
    else $error("Illegal data bits not flagged");
  AST_FMT_OK: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    (conn_i == CONN_MAX && baud_i == 16'h4B00 && db == 4'h8 && par == 4'h2
     && stp == 4'h2 && flw == 4'h2) |-> err_o == RES_OK)
    else $error("Legal parameters rejected");

endmodule : slcc_param_check
`default_nettype wire

// ===== rtl/slcc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module slcc_timer
  import slcc_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic [15:0] limit_i,
  output logic             expired_o
);

  localparam int PW = $clog2(CYC_MS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_MS - 1);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [15:0]   ms;
    logic          exp;
  } slcc_tmr_t;

  slcc_tmr_t t_q, t_d;

  // Millisecond enable from a prescaler; everything clears while idle
  always_comb begin
    t_d = t_q;
    if (!run_i) begin
      t_d = '0;
    end else if (t_q.pre == PRE_LAST) begin
      t_d.pre = '0;
      t_d.ms  = t_q.ms + 16'h0001;
      if (t_q.ms + 16'h0001 >= limit_i) t_d.exp = 1'b1;
    end else begin
      t_d.pre = t_q.pre + PW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) t_q <= '0;
    else       t_q <= t_d;
  end

  assign expired_o = t_q.exp;

endmodule : slcc_timer
`default_nettype wire

// ===== rtl/slcc_top.sv
// Operation
// [RULE1] Port open failure ends command with 2498
// [RULE2] Receive failure reports 2499
// [RULE3] Transmit failure reports 249A
// [RULE4] Command exceeding timeout aborts with 249D
// [RULE5] Timeout zero selects built-in default
// [RULE6] Host retries commands that timed out
// [RULE7] Command while busy rejected with 249E
// [RULE8] Host never overlaps commands on one connection
// [RULE9] Connection number outside 19221..19299 gives 249F
// [RULE10] Baud not in legal list gives 24A0
// [RULE11] Data bits outside 5..8 give 24A1
// [RULE12] Parity above 2 gives 24A2
// [RULE13] Stop bits not 1 or 2 give 24A3
// [RULE14] Flow control above 2 gives 24A4
// [RULE15] Variable memory read failure gives 24AC
// [RULE16] Variable memory write failure gives 24AD
// [RULE17] Unknown command code gives 2497
// [RULE18] One result per command, held until next
`timescale 1ns/10ps
`default_nettype none
module slcc_top
  import slcc_pkg::*;
#(
  parameter int unsigned CYC_MS  = CYC_PER_MS,
  parameter logic [15:0] DEF_TMO = DEF_TMO_MS
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  output logic             busy_o,
  output logic             op_start_o,
  output logic      [2:0]  op_cmd_o,
  output logic      [15:0] op_conn_o,
  output logic      [15:0] op_baud_o,
  output logic      [15:0] op_fmt_o,
  input  wire logic        op_done_i,
  input  wire logic        port_open_fail_i,
  input  wire logic        rx_fail_i,
  input  wire logic        tx_fail_i,
  input  wire logic        vmem_rd_fail_i,
  input  wire logic        vmem_wr_fail_i
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_RUN} slcc_st_t;

  typedef struct packed {
    slcc_st_t    st;
    logic        ack;
    logic [31:0] rdat;
    logic [2:0]  cmd;
    logic [15:0] conn;
    logic [15:0] baud;
    logic [15:0] fmt;
    logic [15:0] tmo;
    logic [15:0] code;
    logic        done;
    logic [15:0] rej;
    logic [2:0]  sts;
    logic [2:0]  msk;
    logic        go;
  } slcc_state_t;

  slcc_state_t s_q, s_d;

  logic        req;
  logic        wr;
  logic        start;
  logic        run;
  logic        tmo_exp;
  logic [15:0] limit;
  logic [15:0] chk_err;
  logic        fin;
  logic [15:0] fin_code;
  logic [2:0]  new_cmd;

  assign req     = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr      = req & wb_we_i;
  assign start   = wr && wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START];
  assign new_cmd = wb_dat_i[CTRL_CMD+:3];
  assign run     = s_q.st == ST_RUN;

  // Zero in the timeout field means the built-in default
  assign limit = (s_q.tmo == 16'h0000) ? DEF_TMO : s_q.tmo; // RULE5

  // ***************************************************************
  // Helpers
  // ***************************************************************
  slcc_param_check u_chk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .conn_i (s_q.conn),
    .baud_i (s_q.baud),
    .fmt_i  (s_q.fmt),
    .err_o  (chk_err)
  );

  slcc_timer #(.CYC_MS(CYC_MS)) u_tmr (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (run),
    .limit_i   (limit),
    .expired_o (tmo_exp)
  );

  // Completion of a running command; link faults outrank the timeout
  always_comb begin
    fin      = 1'b1;
    fin_code = RES_OK;
    if (port_open_fail_i && s_q.cmd == CMD_OPEN) fin_code = ERR_OPEN; // RULE1
    else if (rx_fail_i)      fin_code = ERR_RX;                      // RULE2
    else if (tx_fail_i)      fin_code = ERR_TX;                      // RULE3
    else if (vmem_rd_fail_i) fin_code = ERR_VRD;                     // RULE15
    else if (vmem_wr_fail_i) fin_code = ERR_VWR;                     // RULE16
    else if (tmo_exp)        fin_code = ERR_TMO;                     // RULE4
    else if (!op_done_i)     fin = 1'b0;
  end

  // ***************************************************************
  // Bus slave, command sequencer and interrupt status
  // ***************************************************************
  always_comb begin
    s_d      = s_q;
    s_d.ack  = req;
    s_d.go   = 1'b0;

    // Registered read data; unmapped addresses read as zero
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CTRL: s_d.rdat = {23'h0, s_q.st != ST_IDLE, 4'h0, s_q.cmd, 1'b0};
        ADR_CONN: s_d.rdat = {16'h0, s_q.conn};
        ADR_BAUD: s_d.rdat = {16'h0, s_q.baud};
        ADR_FMT:  s_d.rdat = {16'h0, s_q.fmt};
        ADR_TMO:  s_d.rdat = {16'h0, s_q.tmo};
        ADR_RES:  s_d.rdat = {15'h0, s_q.done, s_q.code};
        ADR_REJ:  s_d.rdat = {16'h0, s_q.rej};
        ADR_ISTS: s_d.rdat = {29'h0, s_q.sts};
        ADR_IMSK: s_d.rdat = {29'h0, s_q.msk};
        default:  s_d.rdat = 32'h0000_0000;
      endcase
    end

    // Descriptor fields are frozen while a command runs
    if (wr && s_q.st == ST_IDLE) begin
      unique case (wb_adr_i)
        ADR_CONN: s_d.conn = slcc_wr16(s_q.conn, wb_dat_i, wb_sel_i);
        ADR_BAUD: s_d.baud = slcc_wr16(s_q.baud, wb_dat_i, wb_sel_i);
        ADR_FMT:  s_d.fmt  = slcc_wr16(s_q.fmt, wb_dat_i, wb_sel_i);
        ADR_TMO:  s_d.tmo  = slcc_wr16(s_q.tmo, wb_dat_i, wb_sel_i);
        default:  ;
      endcase
    end
    if (wr && wb_adr_i == ADR_IMSK && wb_sel_i[0]) s_d.msk = wb_dat_i[2:0];
    // Write one to clear; any set below in this cycle still wins
    if (wr && wb_adr_i == ADR_ISTS && wb_sel_i[0]) s_d.sts = s_q.sts & ~wb_dat_i[2:0];

    // A second command during a running one is refused on its own,
    // so the result of the running command is left untouched
    if (start && s_q.st != ST_IDLE) begin
      s_d.rej          = ERR_BUSY;                     // RULE7
      s_d.sts[IRQ_REJ] = 1'b1;
    end

    unique case (s_q.st)
      ST_IDLE: begin
        if (start) begin
          s_d.cmd  = new_cmd;
          s_d.done = 1'b0;                             // RULE18
          s_d.code = RES_OK;
          if (new_cmd == CMD_OPEN) begin
            s_d.st = ST_CHECK;
          end else if (new_cmd == CMD_READ || new_cmd == CMD_WRITE) begin
            s_d.st = ST_RUN;
            s_d.go = 1'b1;
          end else begin
            s_d.code         = ERR_UNKN;               // RULE17
            s_d.done         = 1'b1;
            s_d.sts[IRQ_DONE] = 1'b1;
            s_d.sts[IRQ_ERR]  = 1'b1;
          end
        end
      end
      ST_CHECK: begin
        if (chk_err != RES_OK) begin
          s_d.st            = ST_IDLE;
          s_d.code          = chk_err;                 // RULE9 RULE10 RULE11 RULE12 RULE13 RULE14
          s_d.done          = 1'b1;
          s_d.sts[IRQ_DONE] = 1'b1;
          s_d.sts[IRQ_ERR]  = 1'b1;
        end else begin
          s_d.st = ST_RUN;
          s_d.go = 1'b1;
        end
      end
      ST_RUN: begin
        if (fin) begin
          s_d.st            = ST_IDLE;
          s_d.code          = fin_code;                // RULE18
          s_d.done          = 1'b1;
          s_d.sts[IRQ_DONE] = 1'b1;
          if (fin_code != RES_OK) s_d.sts[IRQ_ERR] = 1'b1;
        end
      end
    endcase
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) s_q <= '0;
    else       s_q <= s_d;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign wb_ack_o   = s_q.ack;
  assign wb_dat_o   = s_q.rdat;
  assign irq_o      = |(s_q.sts & s_q.msk);
  assign busy_o     = s_q.st != ST_IDLE;
  assign op_start_o = s_q.go;
  assign op_cmd_o   = s_q.cmd;
  assign op_conn_o  = s_q.conn;
  assign op_baud_o  = s_q.baud;
  assign op_fmt_o   = s_q.fmt;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_OPEN_FAIL: assert property (run && s_q.cmd == CMD_OPEN && port_open_fail_i // RULE1
    |=> s_q.st == ST_IDLE && s_q.done && s_q.code == ERR_OPEN)
    else $error("Open failure did not end with its code");
  AST_RX_FAIL: assert property (run && rx_fail_i && !port_open_fail_i // RULE2
    |=> s_q.code == ERR_RX && s_q.done)
    else $error("Receive failure not reported");
  AST_TX_FAIL: assert property (run && tx_fail_i && !rx_fail_i && !port_open_fail_i // RULE3
    |=> s_q.code == ERR_TX && s_q.done)
    else $error("Transmit failure not reported");
  AST_TIMEOUT: assert property (run && tmo_exp && !rx_fail_i && !tx_fail_i // RULE4
    && !vmem_rd_fail_i && !vmem_wr_fail_i && !port_open_fail_i
    |=> s_q.code == ERR_TMO && s_q.st == ST_IDLE)
    else $error("Timeout not reported");
  AST_DEF_TMO: assert property (s_q.tmo == 16'h0000 |-> limit == DEF_TMO) // RULE5
    else $error("Default timeout not selected");
  AST_BUSY_REJ: assert property (start && busy_o // RULE7
    |=> s_q.rej == ERR_BUSY && s_q.sts[IRQ_REJ] && ($stable(s_q.code) || $past(fin && run)))
    else $error("Overlapping command not refused");
  AST_CHECK_ERR: assert property (s_q.st == ST_CHECK && chk_err != RES_OK // RULE9
    |=> s_q.code == $past(chk_err) && s_q.done && !op_start_o)
    else $error("Parameter error not reported");
  AST_VRD_FAIL: assert property (run && vmem_rd_fail_i && !rx_fail_i && !tx_fail_i // RULE15
    && !port_open_fail_i |=> s_q.code == ERR_VRD)
    else $error("Memory read failure not reported");
  AST_VWR_FAIL: assert property (run && vmem_wr_fail_i && !vmem_rd_fail_i && !rx_fail_i // RULE16
    && !tx_fail_i && !port_open_fail_i |=> s_q.code == ERR_VWR)
    else $error("Memory write failure not reported");
  AST_UNKNOWN: assert property (start && !busy_o && new_cmd > CMD_WRITE // RULE17
    |=> s_q.code == ERR_UNKN && s_q.done ##1 !op_start_o)
    else $error("Unknown command not refused");
  AST_HOLD: assert property (s_q.done && !(start && !busy_o) // RULE18
    |=> s_q.done && $stable(s_q.code))
    else $error("Result changed without a new command");

  COV_OK: cover property (run && op_done_i && !tmo_exp ##1 s_q.code == RES_OK);
  COV_TMO: cover property (run ##1 s_q.code == ERR_TMO);
  COV_REJ: cover property (start && busy_o);
  COV_BAD_PARAM: cover property (s_q.st == ST_CHECK && chk_err != RES_OK);

endmodule : slcc_top
`default_nettype wire

// ===== verif/slcc_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// Serial engine stand-in
// ********************
module slcc_engine_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [7:0] lat_i,
  input  wire logic [2:0] mode_i,
  output logic      [5:0] ev_o
);
  logic [7:0] cnt_q;
  logic       act_q;
  // Bit 0 done, bits 1..5 open, rx, tx, read, write fault; 6 and 7 hang
  // Events are one-cycle pulses so a late sample cannot see a stale one
  always_ff @(posedge clk_i) begin
    ev_o <= 6'h00;
    if (rst_i) begin
      act_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (start_i) begin
      act_q <= 1'b1;
      cnt_q <= lat_i;
    end else if (act_q && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (act_q) begin
      act_q <= 1'b0;
      if (mode_i < 3'h6) ev_o[mode_i] <= 1'b1;
    end
  end
endmodule : slcc_engine_model
`default_nettype wire

// ===== verif/slcc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module slcc_top_bench
  import slcc_pkg::*;
();
  localparam int          LIMIT = 20000;
  localparam logic [15:0] FOK   = 16'h0108;
  localparam logic [15:0] B96   = 16'h2580;
  logic        clk, rst, cyc, stb, we, ack, irq, busy, ost;
  logic [7:0]  adr, lat;
  logic [3:0]  sel;
  logic [2:0]  ocmd, mode;
  logic [31:0] dw, dr, rd;
  logic [15:0] oconn, obaud, ofmt;
  logic [5:0]  ev;
  int          n_fail = 0, samples_checked = 0, cycles = 0;
  logic [15:0] bauds [10] = '{16'h004B, 16'h006E, 16'h0096, 16'h012C, 16'h0258,
                              16'h04B0, 16'h0960, 16'h12C0, 16'h2580, 16'h4B00};
  logic [15:0] fmts [8] = '{16'h0104, 16'h0109, 16'h0138, 16'h0008, 16'h0308,
                            16'h3108, 16'h3334, 16'h1125};
  logic [15:0] errs [8] = '{ERR_DBITS, ERR_DBITS, ERR_PARITY, ERR_STOP, ERR_STOP,
                            ERR_FLOW, ERR_DBITS, RES_OK};

  slcc_top #(.CYC_MS(10), .DEF_TMO(16'h0003)) DUT (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .irq_o(irq), .busy_o(busy), .op_start_o(ost), .op_cmd_o(ocmd), .op_conn_o(oconn),
    .op_baud_o(obaud), .op_fmt_o(ofmt), .op_done_i(ev[0]), .port_open_fail_i(ev[1]),
    .rx_fail_i(ev[2]), .tx_fail_i(ev[3]), .vmem_rd_fail_i(ev[4]), .vmem_wr_fail_i(ev[5]));

  slcc_engine_model ENG (.clk_i(clk), .rst_i(rst), .start_i(ost), .lat_i(lat),
                         .mode_i(mode), .ev_o(ev));

  // ********************
  // Clock, reset and watchdog
  // ********************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hung handshake ends the run as a failure; a poll gives up by itself after 400 reads
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      close_out();
    end
  end

  // ********************
  // Bus and check tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Classic cycle: request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d; sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task automatic start(input logic [2:0] c, input logic [15:0] cn, input logic [15:0] b,
                       input logic [15:0] f, input logic [15:0] t, input logic [2:0] m);
    mode <= m;
    wb(1'b1, ADR_CONN, {16'h0000, cn});
    wb(1'b1, ADR_BAUD, {16'h0000, b});
    wb(1'b1, ADR_FMT, {16'h0000, f});
    wb(1'b1, ADR_TMO, {16'h0000, t});
    wb(1'b1, ADR_CTRL, {28'h000_0000, c, 1'b1});
  endtask : start
  // Polls the result word; the next command waits for this
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      wb(1'b0, ADR_RES, 32'h0000_0000);
      k++;
    end while (rd[RES_DONE] !== 1'b1 && k < 400);
  endtask : wait_done
  task automatic run(input logic [2:0] c, input logic [15:0] cn, input logic [15:0] b,
                     input logic [15:0] f, input logic [2:0] m, input logic [15:0] e);
    start(c, cn, b, f, 16'h0000, m);
    wait_done();
    chk(rd, {15'h0000, 1'b1, e});
  endtask : run
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // ********************
  // Test sequence
  // ********************
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    dw = 32'h0000_0000; lat = 8'h04; mode = 3'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    wb(1'b0, ADR_TMO, 32'h0000_0000); chk(rd, 32'h0000_0000);
    wb(1'b0, ADR_IMSK, 32'h0000_0000); chk(rd, 32'h0000_0000);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF); wb(1'b0, 8'h40, 32'h0000_0000); chk(rd, 32'h0000_0000);
    $display("test registers done");
    // Connection bounds, legal baud list, format table
    run(CMD_OPEN, CONN_MIN - 16'h0001, B96, FOK, 3'h0, ERR_CONN);
    run(CMD_OPEN, CONN_MAX + 16'h0001, 16'h0064, FOK, 3'h0, ERR_CONN);
    run(CMD_OPEN, CONN_MIN, B96, FOK, 3'h0, RES_OK);
    run(CMD_OPEN, CONN_MAX, B96, FOK, 3'h0, RES_OK);
    for (int i = 0; i < 10; i++) run(CMD_OPEN, CONN_MIN, bauds[i], FOK, 3'h0, RES_OK);
    run(CMD_OPEN, CONN_MIN, 16'h0064, 16'h0104, 3'h0, ERR_BAUD);
    run(CMD_OPEN, CONN_MIN, 16'h4B01, FOK, 3'h0, ERR_BAUD);
    for (int i = 0; i < 8; i++) run(CMD_OPEN, CONN_MIN, B96, fmts[i], 3'h0, errs[i]);
    run(CMD_OPEN, CONN_MAX, 16'h4B00, 16'h2228, 3'h0, RES_OK);
    $display("test parameters done");
    // Unknown codes, then every engine fault
    for (int c = 3; c < 8; c++) run(c[2:0], CONN_MIN, B96, FOK, 3'h0, ERR_UNKN);
    run(CMD_OPEN, CONN_MIN, B96, FOK, 3'h1, ERR_OPEN);
    run(CMD_READ, CONN_MIN, B96, FOK, 3'h2, ERR_RX);
    run(CMD_WRITE, CONN_MIN, B96, FOK, 3'h3, ERR_TX);
    run(CMD_READ, CONN_MIN, B96, FOK, 3'h4, ERR_VRD);
    run(CMD_WRITE, CONN_MIN, B96, FOK, 3'h5, ERR_VWR);
    $display("test faults done");
    // Explicit limit of 2 ms, then the default of 3 ms; early reads must show no result
    start(CMD_READ, CONN_MIN, B96, FOK, 16'h0002, 3'h6);
    repeat (14) @(posedge clk);
    wb(1'b0, ADR_RES, 32'h0000_0000); chk(rd, 32'h0000_0000);
    wait_done(); chk(rd, {15'h0000, 1'b1, ERR_TMO});
    start(CMD_READ, CONN_MIN, B96, FOK, 16'h0000, 3'h6);
    repeat (24) @(posedge clk);
    wb(1'b0, ADR_RES, 32'h0000_0000); chk(rd, 32'h0000_0000);
    wait_done(); chk(rd, {15'h0000, 1'b1, ERR_TMO});
    run(CMD_READ, CONN_MIN, B96, FOK, 3'h0, RES_OK);
    $display("test timeout done");
    // Second start while busy; running command and its settings must survive
    start(CMD_READ, CONN_MIN, B96, FOK, 16'h0004, 3'h6);
    wb(1'b1, ADR_CONN, 32'h0000_1234);
    chk(busy, 32'h0000_0001);
    wb(1'b1, ADR_CTRL, {28'h000_0000, CMD_WRITE, 1'b1});
    wb(1'b0, ADR_REJ, 32'h0000_0000); chk(rd, {16'h0000, ERR_BUSY});
    wb(1'b0, ADR_ISTS, 32'h0000_0000); chk(rd[IRQ_REJ], 32'h0000_0001);
    chk(oconn, CONN_MIN);
    chk(ocmd, CMD_READ);
    chk(obaud, B96);
    chk(ofmt, FOK);
    wb(1'b0, ADR_CTRL, 32'h0000_0000);
    chk(rd, {23'h00_0000, 1'b1, 4'h0, CMD_READ, 1'b0});
    wait_done(); chk(rd, {15'h0000, 1'b1, ERR_TMO});
    wb(1'b0, ADR_RES, 32'h0000_0000); chk(rd, {15'h0000, 1'b1, ERR_TMO});
    $display("test overlap done");
    // Interrupt: clear, mask error only, then done alone must stay quiet
    wb(1'b1, ADR_ISTS, 32'h0000_0007);
    wb(1'b0, ADR_ISTS, 32'h0000_0000); chk(rd, 32'h0000_0000);
    wb(1'b1, ADR_IMSK, 32'h0000_0002);
    run(CMD_OPEN, CONN_MIN, B96, FOK, 3'h0, RES_OK);
    wb(1'b0, ADR_ISTS, 32'h0000_0000); chk(rd[IRQ_DONE], 32'h0000_0001);
    chk(irq, 32'h0000_0000);
    run(CMD_OPEN, CONN_MAX + 16'h0001, B96, FOK, 3'h0, ERR_CONN);
    chk(irq, 32'h0000_0001);
    wb(1'b1, ADR_ISTS, 32'h0000_0007);
    wb(1'b0, ADR_ISTS, 32'h0000_0000); chk(irq, 32'h0000_0000);
    $display("test interrupt done");
    close_out();
  end
endmodule : slcc_top_bench
`default_nettype wire
